// ==== rtl/mis_top.sv ====
// Transmit mask, combined pending vector, acknowledge and raw receive status.
// Assumes source levels are synchronous to clk_i and the host uses the plain register port.
`timescale 1ns/1ps
module mis_top
  import mis_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [7:0] tx_channel_raw_bit_i,
  input wire logic [7:0] rx_channel_raw_bit_i,
  input wire logic [7:0] rx_threshold_channels_pending_i,
  input wire logic statistics_event_pending_i,
  input wire logic host_error_pending_i,
  input wire logic link_change_pending_i,
  input wire logic mgmt_user_event_pending_i,
  output logic rx_threshold_line_o,
  output logic rx_pulse_line_o,
  output logic tx_pulse_line_o,
  output logic misc_line_o
);
  typedef struct packed {
    logic [7:0] tx_mask;
    logic [31:0] rdata;
    logic [1:0] ack;
    logic [3:0] armed;
    logic [3:0] pulse;
  } mis_state_t;

  logic [1:0] rst_sync_ff;
  logic rst_n;
  mis_state_t st_ff;
  mis_state_t nxt_st;
  logic [7:0] tx_masked;
  logic [31:0] vector;
  logic [3:0] cat_pend;

  // Reset release is synchronised so no flop leaves reset on a different edge.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // One loop entry per transmit channel keeps each gate and its checks side by side.
  for (genvar ch = 0; ch < MIS_CH; ch++) begin : g_ch
    assign tx_masked[ch] = tx_channel_raw_bit_i[ch] & st_ff.tx_mask[ch];

    ch_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      wr_i && addr_i == MIS_OFS_TX_MASK_CLEAR && wdata_i[ch]
      |=> !st_ff.tx_mask[ch])
      else $error("channel mask not cleared");

    ch_clear_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      wr_i && addr_i == MIS_OFS_TX_MASK_CLEAR && !wdata_i[ch]
      |=> st_ff.tx_mask[ch] == $past(st_ff.tx_mask[ch]))
      else $error("zero clear bit changed channel mask");

    ch_set_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      wr_i && addr_i == MIS_OFS_TX_MASK_SET && wdata_i[ch]
      |=> st_ff.tx_mask[ch])
      else $error("channel mask not set");

    ch_set_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      wr_i && addr_i == MIS_OFS_TX_MASK_SET && !wdata_i[ch]
      |=> st_ff.tx_mask[ch] == $past(st_ff.tx_mask[ch]))
      else $error("zero set bit changed channel mask");

    ch_vec_tx_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      rd_i && addr_i == MIS_OFS_VECTOR
      |=> rdata_o[MIS_VEC_TX_LSB + ch] == $past(tx_channel_raw_bit_i[ch] && st_ff.tx_mask[ch]))
      else $error("vector transmit channel bit wrong");

    ch_masked_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      rd_i && addr_i == MIS_OFS_TX_MASKED
      |=> rdata_o[ch] == $past(tx_channel_raw_bit_i[ch] && st_ff.tx_mask[ch]))
      else $error("masked transmit channel bit wrong");

    ch_vec_rxth_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      rd_i && addr_i == MIS_OFS_VECTOR
      |=> rdata_o[MIS_VEC_RXTH_LSB + ch] == $past(rx_threshold_channels_pending_i[ch]))
      else $error("vector threshold channel bit wrong");

    ch_vec_rx_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      rd_i && addr_i == MIS_OFS_VECTOR
      |=> rdata_o[MIS_VEC_RX_LSB + ch] == $past(rx_channel_raw_bit_i[ch]))
      else $error("vector receive channel bit wrong");

    ch_rx_raw_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      rd_i && addr_i == MIS_OFS_RX_RAW
      |=> rdata_o[ch] == $past(rx_channel_raw_bit_i[ch]))
      else $error("raw receive channel bit wrong");
  end

  always_comb begin
    vector = 32'h00000000;
    vector[MIS_VEC_STAT] = statistics_event_pending_i;
    vector[MIS_VEC_HOST] = host_error_pending_i;
    vector[MIS_VEC_LINK] = link_change_pending_i;
    vector[MIS_VEC_USER] = mgmt_user_event_pending_i;
    vector[MIS_VEC_TX_LSB +: MIS_CH] = tx_masked;
    vector[MIS_VEC_RXTH_LSB +: MIS_CH] = rx_threshold_channels_pending_i;
    vector[MIS_VEC_RX_LSB +: MIS_CH] = rx_channel_raw_bit_i;
  end

  // Receive masks live in a neighbouring block, so receive categories use raw levels here.
  assign cat_pend = {statistics_event_pending_i | host_error_pending_i |
                     link_change_pending_i | mgmt_user_event_pending_i,
                     |tx_masked, |rx_channel_raw_bit_i, |rx_threshold_channels_pending_i};

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = MIS_RDATA_RST;
    if (wr_i && addr_i == MIS_OFS_TX_MASK_SET) begin
      nxt_st.tx_mask = st_ff.tx_mask | wdata_i[MIS_CH-1:0];
    end
    if (wr_i && addr_i == MIS_OFS_TX_MASK_CLEAR) begin
      nxt_st.tx_mask = st_ff.tx_mask & ~wdata_i[MIS_CH-1:0];
    end
    // A line pulses once when pending while armed and waits for its acknowledge to re-arm.
    nxt_st.pulse = st_ff.armed & cat_pend;
    nxt_st.armed = st_ff.armed & ~cat_pend;
    if (wr_i && addr_i == MIS_OFS_ACK) begin
      nxt_st.ack = wdata_i[1:0];
      nxt_st.armed[wdata_i[1:0]] = 1'b1;
    end
    if (rd_i) begin
      unique case (addr_i)
        MIS_OFS_TX_RAW: nxt_st.rdata = {24'h000000, tx_channel_raw_bit_i};
        MIS_OFS_TX_MASKED: nxt_st.rdata = {24'h000000, tx_masked};
        MIS_OFS_TX_MASK_SET: nxt_st.rdata = {24'h000000, st_ff.tx_mask};
        MIS_OFS_TX_MASK_CLEAR: nxt_st.rdata = {24'h000000, st_ff.tx_mask};
        MIS_OFS_VECTOR: nxt_st.rdata = vector;
        MIS_OFS_ACK: nxt_st.rdata = {30'h00000000, st_ff.ack};
        MIS_OFS_RX_RAW: nxt_st.rdata = {24'h000000, rx_channel_raw_bit_i};
        default: nxt_st.rdata = MIS_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_ff.tx_mask <= MIS_MASK_RST;
      st_ff.rdata <= MIS_RDATA_RST;
      st_ff.ack <= MIS_ACK_RST;
      st_ff.armed <= 4'hF;
      st_ff.pulse <= 4'h0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdata;
  assign rx_threshold_line_o = st_ff.pulse[MIS_ACK_RXTH];
  assign rx_pulse_line_o = st_ff.pulse[MIS_ACK_RXP];
  assign tx_pulse_line_o = st_ff.pulse[MIS_ACK_TXP];
  assign misc_line_o = st_ff.pulse[MIS_ACK_MISC];

  mask_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_i && addr_i == MIS_OFS_TX_MASK_CLEAR && !(wdata_i[7:0] == 8'h00)
    |=> (st_ff.tx_mask & $past(wdata_i[7:0])) == 8'h00)
    else $error("mask clear did not disable channel");
  mask_set_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_i && addr_i == MIS_OFS_TX_MASK_SET |=> (st_ff.tx_mask & $past(wdata_i[7:0]))
    == $past(wdata_i[7:0]))
    else $error("mask set did not enable channel");
  mask_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !wr_i |=> st_ff.tx_mask == $past(st_ff.tx_mask))
    else $error("mask changed without write");
  vec_read_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rd_i && addr_i == MIS_OFS_VECTOR |=> rdata_o[23:16] == $past(tx_masked)
    && rdata_o[31:28] == 4'h0)
    else $error("vector transmit field wrong");
  vec_misc_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rd_i && addr_i == MIS_OFS_VECTOR |=> rdata_o[27:24] == $past({statistics_event_pending_i,
    host_error_pending_i, link_change_pending_i, mgmt_user_event_pending_i}))
    else $error("vector misc field wrong");
  rx_raw_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rd_i && addr_i == MIS_OFS_RX_RAW |=> rdata_o == {24'h000000, $past(rx_channel_raw_bit_i)})
    else $error("raw receive read wrong");
  vec_rx_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rd_i && addr_i == MIS_OFS_VECTOR |=> rdata_o[15:0] ==
    $past({rx_threshold_channels_pending_i, rx_channel_raw_bit_i}))
    else $error("vector receive fields wrong");
  repulse_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_i && addr_i == MIS_OFS_ACK && wdata_i[1:0] == 2'h2 ##1 (|tx_masked)
    |=> tx_pulse_line_o)
    else $error("transmit line not pulsed after acknowledge");
  ack_store_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_i && addr_i == MIS_OFS_ACK ##1 rd_i && addr_i == MIS_OFS_ACK
    |=> rdata_o[1:0] == $past(wdata_i[1:0], 2))
    else $error("acknowledge code not kept");

  mask_read_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rd_i && addr_i == MIS_OFS_TX_MASK_CLEAR
    |=> rdata_o == {24'h000000, $past(st_ff.tx_mask)})
    else $error("mask clear read wrong");

  ack_upper_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rd_i && addr_i == MIS_OFS_ACK
    |=> rdata_o[31:2] == 30'h00000000)
    else $error("acknowledge upper bits not zero");

  ack_code_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_i && addr_i == MIS_OFS_ACK
    |=> st_ff.ack == $past(wdata_i[1:0]))
    else $error("acknowledge code not stored");

  // A second pulse back to back is only legal when software re-armed the line at once.
  tx_once_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    tx_pulse_line_o && !$past(wr_i && addr_i == MIS_OFS_ACK && wdata_i[1:0] == MIS_ACK_TXP)
    |=> !tx_pulse_line_o)
    else $error("transmit line pulsed twice");

  misc_once_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    misc_line_o && !$past(wr_i && addr_i == MIS_OFS_ACK && wdata_i[1:0] == MIS_ACK_MISC)
    |=> !misc_line_o)
    else $error("misc line pulsed twice");

  rxp_once_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rx_pulse_line_o && !$past(wr_i && addr_i == MIS_OFS_ACK && wdata_i[1:0] == MIS_ACK_RXP)
    |=> !rx_pulse_line_o)
    else $error("receive line pulsed twice");

  rxth_once_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rx_threshold_line_o && !$past(wr_i && addr_i == MIS_OFS_ACK && wdata_i[1:0] == MIS_ACK_RXTH)
    |=> !rx_threshold_line_o)
    else $error("threshold line pulsed twice");

  tx_cause_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    tx_pulse_line_o
    |-> $past(|tx_masked))
    else $error("transmit line pulsed without enabled source");

  misc_cause_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    misc_line_o
    |-> $past(statistics_event_pending_i || host_error_pending_i ||
    link_change_pending_i || mgmt_user_event_pending_i))
    else $error("misc line pulsed without source");

  rx_cause_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rx_pulse_line_o
    |-> $past(|rx_channel_raw_bit_i))
    else $error("receive line pulsed without source");

  rxth_cause_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rx_threshold_line_o
    |-> $past(|rx_threshold_channels_pending_i))
    else $error("threshold line pulsed without source");

  c_clear: cover property (@(posedge clk_i) wr_i && addr_i == MIS_OFS_TX_MASK_CLEAR);
  c_ack: cover property (@(posedge clk_i) wr_i && addr_i == MIS_OFS_ACK ##2 tx_pulse_line_o);
  c_vec: cover property (@(posedge clk_i) rd_i && addr_i == MIS_OFS_VECTOR ##1 rdata_o != 0);
  c_zero_clear: cover property (@(posedge clk_i)
    wr_i && addr_i == MIS_OFS_TX_MASK_CLEAR && wdata_i[7:0] == 8'h00);
  c_misc: cover property (@(posedge clk_i) misc_line_o);
endmodule

// ==== rtl/mis_pkg.sv ====
// Constants for the interrupt status and mask block of the media access controller.
// Assumes a plain register port and that the pending sources are levels from the same clock.
package mis_pkg;
  localparam int unsigned MIS_CH = 8;
  localparam logic [7:0] MIS_OFS_TX_RAW = 8'h00;
  localparam logic [7:0] MIS_OFS_TX_MASKED = 8'h04;
  localparam logic [7:0] MIS_OFS_TX_MASK_SET = 8'h08;
  localparam logic [7:0] MIS_OFS_TX_MASK_CLEAR = 8'h0C;
  localparam logic [7:0] MIS_OFS_VECTOR = 8'h10;
  localparam logic [7:0] MIS_OFS_ACK = 8'h14;
  localparam logic [7:0] MIS_OFS_RX_RAW = 8'h18;
  localparam int unsigned MIS_VEC_STAT = 27;
  localparam int unsigned MIS_VEC_HOST = 26;
  localparam int unsigned MIS_VEC_LINK = 25;
  localparam int unsigned MIS_VEC_USER = 24;
  localparam int unsigned MIS_VEC_TX_LSB = 16;
  localparam int unsigned MIS_VEC_RXTH_LSB = 8;
  localparam int unsigned MIS_VEC_RX_LSB = 0;
  localparam logic [7:0] MIS_MASK_RST = 8'h00;
  localparam logic [31:0] MIS_RDATA_RST = 32'h00000000;
  localparam logic [1:0] MIS_ACK_RST = 2'h0;
  typedef enum logic [1:0] {
    MIS_ACK_RXTH = 2'h0,
    MIS_ACK_RXP = 2'h1,
    MIS_ACK_TXP = 2'h2,
    MIS_ACK_MISC = 2'h3
  } mis_ack_code_t;
endpackage

// ==== tb/mis_host_model.sv ====
// Host interrupt controller model: counts the pulses seen on the four service lines.
// Assumes the lines are one-cycle pulses synchronous to clk_i, index 0 rx threshold.
`timescale 1ns/1ps
module mis_host_model (
  input wire logic clk_i,
  input wire logic [3:0] line_i,
  output logic [3:0][7:0] hits_o = '0
);
  // A line stuck high counts every cycle, so a missing disarm shows up as extra hits.
  always @(posedge clk_i) begin
    for (int k = 0; k < 4; k++) begin
      if (line_i[k] === 1'b1) hits_o[k] <= hits_o[k] + 8'h01;
    end
  end
endmodule

// ==== tb/mis_top_test.sv ====
// Self-checking bench for mis_top: masks, status, vector and acknowledge re-arming.
// Assumes mis_host_model counts service line pulses beside the design.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module mis_top_test;
  import mis_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, tx = 8'h00, rx = 8'h00, rxth = 8'h00, m = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata, d;
  logic st = 1'b0, ho = 1'b0, li = 1'b0, us = 1'b0;
  logic [3:0] lines;
  logic [3:0][7:0] hits;
  logic [7:0] h0;
  int num_errors = 0, comparisons = 0, cyc = 0;
  mis_top mis_top_inst (.clk_i(clk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tx_channel_raw_bit_i(tx),
    .rx_channel_raw_bit_i(rx), .rx_threshold_channels_pending_i(rxth),
    .statistics_event_pending_i(st), .host_error_pending_i(ho),
    .link_change_pending_i(li), .mgmt_user_event_pending_i(us),
    .rx_threshold_line_o(lines[0]), .rx_pulse_line_o(lines[1]),
    .tx_pulse_line_o(lines[2]), .misc_line_o(lines[3]));
  mis_host_model mis_host_model_inst (.clk_i(clk), .line_i(lines), .hits_o(hits));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // The run is a few hundred cycles; the ceiling leaves ample margin for a hang.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 v = rdata;
  endtask
  function automatic logic [31:0] vec_exp();
    return {4'h0, st, ho, li, us, tx & m, rxth, rx};
  endfunction
  initial begin
    void'($urandom(32'h61177a88));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(MIS_OFS_TX_MASK_CLEAR, d); `CHK("mask", 32'h00000000, d)
    rd_reg(MIS_OFS_ACK, d); `CHK("ack", 32'h00000000, d)
    rd_reg(MIS_OFS_RX_RAW, d); `CHK("rxraw", 32'h00000000, d)
    for (int i = 0; i < 24; i++) begin
      @(posedge clk); tx <= $urandom; rx <= $urandom; rxth <= $urandom;
      {st, ho, li, us} <= $urandom;
      d = (i == 0) ? 32'hFFFFFFFF : $urandom; wr_reg(MIS_OFS_TX_MASK_SET, d);
      m = m | d[7:0];
      d = (i == 1) ? 32'h00000000 : $urandom; wr_reg(MIS_OFS_TX_MASK_CLEAR, d);
      m = m & ~d[7:0];
      wr_reg(MIS_OFS_VECTOR, $urandom);
      rd_reg(MIS_OFS_TX_MASK_CLEAR, d); `CHK("mask", {24'h0, m}, d)
      rd_reg(MIS_OFS_TX_MASKED, d); `CHK("masked", {24'h0, tx & m}, d)
      rd_reg(MIS_OFS_VECTOR, d); `CHK("vector", vec_exp(), d)
      rd_reg(MIS_OFS_RX_RAW, d); `CHK("rxraw", {24'h0, rx}, d)
      rd_reg(8'h20, d); `CHK("unmapped", 32'h00000000, d)
    end
    // Every category is kept pending so each acknowledge must bring exactly one new pulse.
    @(posedge clk); tx <= 8'hFF; rx <= 8'h01; rxth <= 8'h80; st <= 1'b1;
    wr_reg(MIS_OFS_TX_MASK_SET, 32'h000000FF);
    repeat (4) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      h0 = hits[k];
      wr_reg(MIS_OFS_ACK, {30'h0, k[1:0]});
      repeat (3) @(posedge clk);
      #1 `CHK("pulses", h0 + 8'h01, hits[k])
      rd_reg(MIS_OFS_ACK, d); `CHK("ack", {30'h0, k[1:0]}, d)
    end
    report_and_stop();
  end
endmodule
